// File: hw/frs_pkg.sv
// constants, types and helpers shared by both ends of the flash link
// assumes a 40 MHz system clock on the design side of each end
package frs_pkg;
  // =====================================================================
  // opcodes
  localparam logic [7:0] OP_SET_READ_PARAM = 8'hc0;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_READ_DISCOVERY = 8'h5a;

  // =====================================================================
  // frame shape
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DISC_DUMMY_BITS = 8;
  localparam int PARAM_BITS = 8;

  // =====================================================================
  // read parameter fields and defaults
  localparam int DUMMY_SEL_BIT = 4;
  localparam int WRAP_SEL_LSB = 0;
  localparam logic DUMMY_SEL_RESET = 1'b0;
  localparam logic [1:0] WRAP_SEL_RESET = 2'h0;
  localparam logic [2:0] DUMMY_CLOCKS_SLOW = 3'h4;
  localparam logic [2:0] DUMMY_CLOCKS_FAST = 3'h6;
  localparam logic [6:0] WRAP_BYTES_MIN = 7'h08;

  // =====================================================================
  // discovery area
  localparam int DISC_ADDR_W = 11;
  localparam logic [7:0] DISC_BLANK = 8'hff;
  localparam logic [31:0] DISC_SIGNATURE = 32'h50444653;
  localparam logic [31:0] DISC_ARRAY_BITS_M1 = 32'h01ffffff;

  // =====================================================================
  // timing
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int RST_TIME_NS = 30000;
  localparam int RST_CYCLES =
    (RST_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int HOST_RST_MARGIN = 8;
  localparam int HOST_HALF_PERIOD = 4;

  // =====================================================================
  // states
  typedef enum logic [2:0] {
    L_OPCODE, L_ADDR, L_DUMMY, L_DATA, L_PARAM, L_IGNORE
  } frs_link_state_t;

  typedef enum logic [1:0] {H_IDLE, H_FRAME, H_WAIT} frs_host_state_t;

  // =====================================================================
  // helpers
  function automatic logic [2:0] dummy_clocks(input logic sel);
    return sel ? DUMMY_CLOCKS_FAST : DUMMY_CLOCKS_SLOW;
  endfunction

  function automatic logic [6:0] wrap_bytes(input logic [1:0] sel);
    return WRAP_BYTES_MIN << sel;
  endfunction
endpackage

// File: hw/frs_spi_if.sv
// serial link between host end and flash end
// miso idles high through a pull-up when the flash does not drive it
`timescale 1ns/100ps
interface frs_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev (
    input cs_n,
    input sclk,
    input mosi,
    output miso,
    output miso_oe
  );
  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input miso_line
  );
endinterface

// File: hw/frs_sfdp_rom.sv
// read-only discovery table, 2048 bytes, combinational lookup
// assumes a registered address from the caller
`timescale 1ns/100ps
module frs_sfdp_rom #(
  // arbitrary neutral maker code
  parameter logic [7:0] MAKER_CODE = 8'h5c
) (
  input logic [frs_pkg::DISC_ADDR_W-1:0] i_addr,
  output logic [7:0] o_data
);
  // =====================================================================
  // table
  always_comb begin
    unique case (i_addr)
      11'h000: o_data = frs_pkg::DISC_SIGNATURE[7:0];
      11'h001: o_data = frs_pkg::DISC_SIGNATURE[15:8];
      11'h002: o_data = frs_pkg::DISC_SIGNATURE[23:16];
      11'h003: o_data = frs_pkg::DISC_SIGNATURE[31:24];
      11'h004: o_data = 8'h01;
      11'h005: o_data = 8'h01;
      11'h006: o_data = 8'h00;
      11'h008: o_data = MAKER_CODE;
      11'h009: o_data = 8'h00;
      11'h00a: o_data = 8'h01;
      11'h00b: o_data = 8'h04;
      11'h00c: o_data = 8'h80;
      11'h00d: o_data = 8'h00;
      11'h00e: o_data = 8'h00;
      11'h080: o_data = 8'he5;
      11'h081: o_data = 8'h20;
      11'h082: o_data = 8'hf1;
      11'h084: o_data = frs_pkg::DISC_ARRAY_BITS_M1[7:0];
      11'h085: o_data = frs_pkg::DISC_ARRAY_BITS_M1[15:8];
      11'h086: o_data = frs_pkg::DISC_ARRAY_BITS_M1[23:16];
      11'h087: o_data = frs_pkg::DISC_ARRAY_BITS_M1[31:24];
      11'h088: o_data = 8'h44;
      11'h089: o_data = 8'heb;
      11'h08a: o_data = 8'h08;
      11'h08b: o_data = 8'h6b;
      11'h08c: o_data = 8'h08;
      11'h08d: o_data = 8'h3b;
      11'h08e: o_data = 8'h80;
      11'h08f: o_data = 8'hbb;
      11'h090: o_data = 8'hfe;
      default: o_data = frs_pkg::DISC_BLANK;
    endcase
  end
endmodule

// File: hw/frs_flash_end.sv
// flash end: read parameters, software reset pair, discovery read
// link logic runs on the host's serial clock, which only runs in frames;
// one bit per clock on mosi and miso in both command modes
`timescale 1ns/100ps

// Summary of operation
// - quad mode C0h sets dummy and wrap
// - C0h ignored in standard spi mode
// - spi wrap setting survives quad mode entry
// - defaults: 8 byte wrap, 4 dummy clocks
// - reset aborts work, clears volatile state
// - 66h and 99h work in both modes
// - 99h must directly follow 66h
// - 30us reset time, commands rejected meanwhile
// - host checks busy and suspend first
// - 2048 byte read-only area, blank is ffh
// - 5Ah, 24-bit address, 8 dummy, data
// - data out on falling edge, cs ends
// - signature, revision and header count bytes
// - header revision, length and table pointer
// - byte 80h e5h, 81h 20h
// - byte 82h f1h read modes
// - bytes 84h-87h array size 01ffffffh
// - bytes 88h-89h 44h, ebh
// - bytes 8ah-8fh dual and quad reads
// - byte 90h feh quad fast read
// - reserved bytes read ffh
module frs_flash_end #(
  parameter int RST_CYCLES = frs_pkg::RST_CYCLES
) (
  input logic i_sys_clk,
  input logic i_sys_rst,
  frs_spi_if.dev spi,
  input logic i_quad_command_mode,
  input logic i_spi_wrap_load,
  input logic [1:0] i_spi_wrap_size_bits,
  output logic o_dummy_cycle_select,
  output logic [2:0] o_dummy_clocks,
  output logic [1:0] o_wrap_length_select,
  output logic [6:0] o_wrap_bytes,
  output logic o_soft_reset,
  output logic o_reset_busy
);
  localparam int AW = frs_pkg::DISC_ADDR_W;
  localparam int CW = $clog2(RST_CYCLES + 1);
  localparam logic [4:0] OP_LAST = 5'(frs_pkg::OPCODE_BITS - 1);
  localparam logic [4:0] ADDR_LAST = 5'(frs_pkg::ADDR_BITS - 1);
  localparam logic [4:0] DUMMY_LAST = 5'(frs_pkg::DISC_DUMMY_BITS - 1);
  localparam logic [4:0] PARAM_LAST = 5'(frs_pkg::PARAM_BITS - 1);

  if (RST_CYCLES < 1) begin : g_chk
    $error("RST_CYCLES must be at least one");
  end

  frs_pkg::frs_link_state_t state;
  logic [4:0] bit_cnt;
  logic [6:0] op_sr;
  logic [AW-1:0] rd_addr;
  logic [7:0] rom_byte;
  logic link_rst;
  logic op_done;
  logic [7:0] op_byte;
  logic quad_meta;
  logic quad_sync;
  logic busy_meta;
  logic busy_sync;
  logic rst_armed;
  logic rst_tgl;
  logic par_tgl;
  logic [7:0] par_data;
  logic [2:0] rst_sync;
  logic [2:0] par_sync;
  logic rst_evt;
  logic par_evt;
  logic [CW-1:0] busy_cnt;

  // =====================================================================
  // link side: frame decode on rising sclk, ended by cs_n high
  assign link_rst = i_sys_rst | spi.cs_n;
  assign op_done = (state == frs_pkg::L_OPCODE) && (bit_cnt == OP_LAST);
  assign op_byte = {op_sr, spi.mosi};

  always_ff @(posedge spi.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quad_meta <= 1'b0;
      quad_sync <= 1'b0;
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      quad_meta <= i_quad_command_mode;
      quad_sync <= quad_meta;
      busy_meta <= o_reset_busy;
      busy_sync <= busy_meta;
    end
  end

  always_ff @(posedge spi.sclk or posedge link_rst) begin
    if (link_rst) begin
      state <= frs_pkg::L_OPCODE;
      bit_cnt <= 5'h00;
      op_sr <= 7'h00;
      rd_addr <= '0;
    end else begin
      op_sr <= op_byte[6:0];
      bit_cnt <= bit_cnt + 5'h01;
      unique case (state)
        frs_pkg::L_OPCODE: begin
          if (op_done) begin
            bit_cnt <= 5'h00;
            if (busy_sync) begin
              state <= frs_pkg::L_IGNORE;
            end else if (op_byte == frs_pkg::OP_READ_DISCOVERY) begin
              state <= frs_pkg::L_ADDR;
            end else if (op_byte == frs_pkg::OP_SET_READ_PARAM &&
                         quad_sync) begin
              state <= frs_pkg::L_PARAM;
            end else begin
              state <= frs_pkg::L_IGNORE;
            end
          end
        end
        frs_pkg::L_ADDR: begin
          // upper address bits fold onto the 2048 byte area
          rd_addr <= {rd_addr[AW-2:0], spi.mosi};
          if (bit_cnt == ADDR_LAST) begin
            bit_cnt <= 5'h00;
            state <= frs_pkg::L_DUMMY;
          end
        end
        frs_pkg::L_DUMMY: begin
          if (bit_cnt == DUMMY_LAST) begin
            bit_cnt <= 5'h00;
            state <= frs_pkg::L_DATA;
          end
        end
        frs_pkg::L_DATA: begin
          bit_cnt <= {2'h0, bit_cnt[2:0] + 3'h1};
          if (bit_cnt[2:0] == 3'h7) begin
            rd_addr <= rd_addr + 11'h001;
          end
        end
        frs_pkg::L_PARAM: begin
          if (bit_cnt == PARAM_LAST) begin
            state <= frs_pkg::L_IGNORE;
          end
        end
        frs_pkg::L_IGNORE: begin
          bit_cnt <= bit_cnt;
        end
      endcase
    end
  end

  // reset pair and parameter byte outlive the frame
  always_ff @(posedge spi.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_armed <= 1'b0;
      rst_tgl <= 1'b0;
    end else if (op_done && !busy_sync) begin
      rst_armed <= (op_byte == frs_pkg::OP_RESET_ENABLE);
      if (op_byte == frs_pkg::OP_RESET && rst_armed) begin
        rst_tgl <= ~rst_tgl;
      end
    end
  end

  always_ff @(posedge spi.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      par_tgl <= 1'b0;
      par_data <= 8'h00;
    end else if (state == frs_pkg::L_PARAM && bit_cnt == PARAM_LAST) begin
      par_data <= op_byte;
      par_tgl <= ~par_tgl;
    end
  end

  always_ff @(negedge spi.sclk or posedge link_rst) begin
    if (link_rst) begin
      spi.miso <= 1'b0;
      spi.miso_oe <= 1'b0;
    end else begin
      spi.miso <= rom_byte[3'h7 - bit_cnt[2:0]];
      spi.miso_oe <= (state == frs_pkg::L_DATA);
    end
  end

  frs_sfdp_rom u_rom (
    .i_addr(rd_addr),
    .o_data(rom_byte)
  );

  // =====================================================================
  // system side: event crossing, parameters, reset timer
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_sync <= 3'h0;
      par_sync <= 3'h0;
    end else begin
      rst_sync <= {rst_sync[1:0], rst_tgl};
      par_sync <= {par_sync[1:0], par_tgl};
    end
  end

  assign rst_evt = rst_sync[2] ^ rst_sync[1];
  assign par_evt = par_sync[2] ^ par_sync[1];

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dummy_cycle_select <= frs_pkg::DUMMY_SEL_RESET;
      o_dummy_clocks <= frs_pkg::DUMMY_CLOCKS_SLOW;
    end else if (rst_evt) begin
      o_dummy_cycle_select <= frs_pkg::DUMMY_SEL_RESET;
      o_dummy_clocks <= frs_pkg::DUMMY_CLOCKS_SLOW;
    end else if (par_evt && !o_reset_busy) begin
      o_dummy_cycle_select <= par_data[frs_pkg::DUMMY_SEL_BIT];
      o_dummy_clocks <=
        frs_pkg::dummy_clocks(par_data[frs_pkg::DUMMY_SEL_BIT]);
    end
  end

  // mode changes leave the wrap setting alone
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wrap_length_select <= frs_pkg::WRAP_SEL_RESET;
      o_wrap_bytes <= frs_pkg::WRAP_BYTES_MIN;
    end else if (rst_evt) begin
      o_wrap_length_select <= frs_pkg::WRAP_SEL_RESET;
      o_wrap_bytes <= frs_pkg::WRAP_BYTES_MIN;
    end else if (par_evt && !o_reset_busy) begin
      o_wrap_length_select <=
        par_data[frs_pkg::WRAP_SEL_LSB +: 2];
      o_wrap_bytes <=
        frs_pkg::wrap_bytes(par_data[frs_pkg::WRAP_SEL_LSB +: 2]);
    end else if (i_spi_wrap_load && !o_reset_busy) begin
      o_wrap_length_select <= i_spi_wrap_size_bits;
      o_wrap_bytes <= frs_pkg::wrap_bytes(i_spi_wrap_size_bits);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_cnt <= '0;
      o_reset_busy <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= rst_evt;
      if (rst_evt) begin
        busy_cnt <= CW'(RST_CYCLES);
        o_reset_busy <= 1'b1;
      end else if (busy_cnt != '0) begin
        busy_cnt <= busy_cnt - CW'(1);
        o_reset_busy <= (busy_cnt != CW'(1));
      end
    end
  end
endmodule

// File: hw/frs_host_end.sv
// host end: sends one command frame per accepted request, reads discovery bytes
// sclk is the system clock divided down; miso is resynchronised
`timescale 1ns/100ps
module frs_host_end #(
  parameter int HALF_PERIOD = frs_pkg::HOST_HALF_PERIOD,
  parameter int RST_WAIT = frs_pkg::RST_CYCLES + frs_pkg::HOST_RST_MARGIN
) (
  input logic i_sys_clk,
  input logic i_sys_rst,
  frs_spi_if.host spi,
  input logic i_cmd_valid,
  input logic [7:0] i_cmd_opcode,
  input logic [23:0] i_cmd_addr,
  input logic [7:0] i_cmd_param,
  input logic [7:0] i_cmd_read_bytes,
  input logic i_busy_or_suspend,
  output logic o_cmd_ready,
  output logic o_cmd_done,
  output logic o_cmd_refused,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [2:0] o_dummy_clocks
);
  localparam int DW = $clog2(HALF_PERIOD);
  localparam int WW = $clog2(RST_WAIT + 1);
  localparam logic [11:0] DISC_HDR_BITS = 12'(frs_pkg::OPCODE_BITS +
    frs_pkg::ADDR_BITS + frs_pkg::DISC_DUMMY_BITS);
  localparam logic [11:0] PARAM_FRAME_BITS =
    12'(frs_pkg::OPCODE_BITS + frs_pkg::PARAM_BITS);
  localparam logic [11:0] OP_FRAME_BITS = 12'(frs_pkg::OPCODE_BITS);

  // the flash may run a shortened reset time, so no lower bound beyond one
  if (HALF_PERIOD < 2 || RST_WAIT < 1) begin : g_chk
    $error("HALF_PERIOD below 2 or RST_WAIT below one");
  end

  frs_pkg::frs_host_state_t state;
  logic [DW-1:0] div_cnt;
  logic [39:0] out_sr;
  logic [11:0] out_bits;
  logic [11:0] total_bits;
  logic [11:0] rise_cnt;
  logic [11:0] rd_pos;
  logic [7:0] in_sr;
  logic [7:0] cur_op;
  logic [WW-1:0] wait_cnt;
  logic miso_meta;
  logic miso_sync;
  logic reset_op;
  logic accept;

  assign reset_op = (i_cmd_opcode == frs_pkg::OP_RESET_ENABLE) ||
                    (i_cmd_opcode == frs_pkg::OP_RESET);
  assign accept = (state == frs_pkg::H_IDLE) && o_cmd_ready &&
                  i_cmd_valid && !(reset_op && i_busy_or_suspend);
  assign rd_pos = rise_cnt - out_bits;

  // =====================================================================
  // miso resync
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      miso_meta <= 1'b1;
      miso_sync <= 1'b1;
    end else begin
      miso_meta <= spi.miso_line;
      miso_sync <= miso_meta;
    end
  end

  // =====================================================================
  // dummy count the host keeps for later fast reads: set by any accepted C0h, back to 4 on any accepted 99h
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dummy_clocks <= frs_pkg::DUMMY_CLOCKS_SLOW;
    end else if (accept && i_cmd_opcode == frs_pkg::OP_SET_READ_PARAM) begin
      o_dummy_clocks <=
        frs_pkg::dummy_clocks(i_cmd_param[frs_pkg::DUMMY_SEL_BIT]);
    end else if (accept && i_cmd_opcode == frs_pkg::OP_RESET) begin
      o_dummy_clocks <= frs_pkg::DUMMY_CLOCKS_SLOW;
    end
  end

  // =====================================================================
  // frame sequencer
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= frs_pkg::H_IDLE;
      spi.cs_n <= 1'b1;
      spi.sclk <= 1'b0;
      spi.mosi <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_cmd_done <= 1'b0;
      o_cmd_refused <= 1'b0;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
      div_cnt <= '0;
      out_sr <= 40'h0;
      out_bits <= 12'h000;
      total_bits <= 12'h000;
      rise_cnt <= 12'h000;
      in_sr <= 8'h00;
      cur_op <= 8'h00;
      wait_cnt <= '0;
    end else begin
      o_cmd_done <= 1'b0;
      o_cmd_refused <= 1'b0;
      o_rd_valid <= 1'b0;
      unique case (state)
        frs_pkg::H_IDLE: begin
          o_cmd_ready <= !(o_cmd_ready && i_cmd_valid);
          if (o_cmd_ready && i_cmd_valid && !accept) begin
            o_cmd_refused <= 1'b1;
            o_cmd_done <= 1'b1;
          end
          if (accept) begin
            state <= frs_pkg::H_FRAME;
            spi.cs_n <= 1'b0;
            spi.mosi <= i_cmd_opcode[7];
            cur_op <= i_cmd_opcode;
            div_cnt <= '0;
            rise_cnt <= 12'h000;
            if (i_cmd_opcode == frs_pkg::OP_READ_DISCOVERY) begin
              out_sr <= {i_cmd_opcode, i_cmd_addr, 8'h00};
              out_bits <= DISC_HDR_BITS;
              total_bits <= DISC_HDR_BITS + {1'b0, i_cmd_read_bytes, 3'h0};
            end else if (i_cmd_opcode == frs_pkg::OP_SET_READ_PARAM) begin
              out_sr <= {i_cmd_opcode, i_cmd_param, 24'h0};
              out_bits <= PARAM_FRAME_BITS;
              total_bits <= PARAM_FRAME_BITS;
            end else begin
              out_sr <= {i_cmd_opcode, 32'h0};
              out_bits <= OP_FRAME_BITS;
              total_bits <= OP_FRAME_BITS;
            end
          end
        end
        frs_pkg::H_FRAME: begin
          if (div_cnt == DW'(HALF_PERIOD - 1)) begin
            div_cnt <= '0;
            spi.sclk <= ~spi.sclk;
            if (!spi.sclk) begin
              rise_cnt <= rise_cnt + 12'h001;
            end else begin
              // sample on falling edge, one clock after the flash drove
              if (rise_cnt > out_bits) begin
                in_sr <= {in_sr[6:0], miso_sync};
                if (rd_pos[2:0] == 3'h0) begin
                  o_rd_data <= {in_sr[6:0], miso_sync};
                  o_rd_valid <= 1'b1;
                end
              end
              if (rise_cnt == total_bits) begin
                spi.cs_n <= 1'b1;
                o_cmd_done <= 1'b1;
                wait_cnt <= WW'(RST_WAIT);
                if (cur_op == frs_pkg::OP_RESET) begin
                  state <= frs_pkg::H_WAIT;
                end else begin
                  state <= frs_pkg::H_IDLE;
                end
              end else begin
                out_sr <= {out_sr[38:0], 1'b0};
                spi.mosi <= out_sr[38];
              end
            end
          end else begin
            div_cnt <= div_cnt + DW'(1);
          end
        end
        frs_pkg::H_WAIT: begin
          wait_cnt <= wait_cnt - WW'(1);
          if (wait_cnt == WW'(1)) begin
            state <= frs_pkg::H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: verification/frs_asserts.sv
// checker for the link and the read parameters of the flash end
// assumes one 40 MHz system clock domain and an async high reset
`timescale 1ns/100ps
module frs_asserts #(
  parameter int RST_CYCLES = 20
) (
  input logic i_sys_clk,
  input logic i_sys_rst,
  input logic i_cs_n,
  input logic i_sclk,
  input logic i_miso_oe,
  input logic i_quad_command_mode,
  input logic i_dummy_cycle_select,
  input logic [2:0] i_dummy_clocks,
  input logic [1:0] i_wrap_length_select,
  input logic [6:0] i_wrap_bytes,
  input logic i_soft_reset,
  input logic i_reset_busy
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  // =====================================================================
  // busy length counter
  int busy_cnt;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      busy_cnt <= 0;
    else if (i_reset_busy)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end

  // =====================================================================
  // assertions
  oe_release_a: assert property (i_cs_n && $past(i_cs_n) |->
    !i_miso_oe)
    else $error("miso driven while deselected");
  sclk_idle_a: assert property (i_cs_n && $past(i_cs_n) |->
    !i_sclk)
    else $error("serial clock runs outside a frame");
  dummy_map_a: assert property ($stable(i_dummy_cycle_select) |->
    i_dummy_clocks == (i_dummy_cycle_select ? 3'h6 : 3'h4))
    else $error("dummy count does not match select");
  wrap_map_a: assert property ($stable(i_wrap_length_select) |->
    i_wrap_bytes == (7'h08 << i_wrap_length_select))
    else $error("wrap bytes do not match select");
  reset_defaults_a: assert property (i_soft_reset |-> ##[1:2]
    (i_reset_busy && !i_dummy_cycle_select && i_wrap_length_select == 2'h0))
    else $error("defaults not restored after soft reset");
  reset_pulse_a: assert property (i_soft_reset |=> !i_soft_reset)
    else $error("soft reset longer than one cycle");
  busy_len_a: assert property ($fell(i_reset_busy) |->
    busy_cnt == RST_CYCLES)
    else $error("reset busy time wrong");
  busy_hold_a: assert property (i_reset_busy &&
    $past(i_reset_busy, 3) |->
    $stable(i_wrap_length_select) && $stable(i_dummy_cycle_select))
    else $error("parameters changed while resetting");
  reset_gate_a: assert property (i_soft_reset |->
    !$past(i_reset_busy))
    else $error("reset accepted while busy");
  quad_gate_a: assert property ($rose(i_dummy_cycle_select) |->
    i_quad_command_mode)
    else $error("dummy select set outside quad mode");
endmodule

// File: verification/flash_readparam_reset_sfdp_tb.sv
// bench: host end and flash end joined on one link
// assumes a shortened reset time and the default maker code
`timescale 1ns/100ps
module flash_readparam_reset_sfdp_tb;
  logic clk = 0;
  logic rst = 1;
  logic qm = 0, wl = 0, v = 0, bs = 0, rdy, dn, rf, rv, sel, sr, bz, rfd;
  logic [1:0] wb = 0;
  logic [1:0] wsel;
  logic [7:0] op = 0, pa = 0, nb = 0, rd, p;
  logic [23:0] ad = 0, a;
  logic [2:0] dc, hdc;
  logic [6:0] wby;
  logic [7:0] q[$];
  int seed = 81, error_cnt = 0, checks = 0, srs = 0;
  // maker code, arbitrary value
  localparam logic [7:0] MK = 8'h5c;
  localparam logic [0:127] LO = {64'h53464450010100ff, MK, 56'h000104800000ff};
  localparam logic [0:135] HI = 136'he520f1ffffffff0144eb086b083b80bbfe;

  frs_spi_if spi();
  frs_flash_end #(.RST_CYCLES(20)) i_frs_flash_end (.i_sys_clk(clk),
    .i_sys_rst(rst), .spi(spi.dev), .i_quad_command_mode(qm),
    .i_spi_wrap_load(wl), .i_spi_wrap_size_bits(wb),
    .o_dummy_cycle_select(sel), .o_dummy_clocks(dc),
    .o_wrap_length_select(wsel), .o_wrap_bytes(wby), .o_soft_reset(sr),
    .o_reset_busy(bz));
  frs_host_end #(.HALF_PERIOD(4), .RST_WAIT(28)) i_frs_host_end (
    .i_sys_clk(clk), .i_sys_rst(rst), .spi(spi.host), .i_cmd_valid(v),
    .i_cmd_opcode(op), .i_cmd_addr(ad), .i_cmd_param(pa),
    .i_cmd_read_bytes(nb), .i_busy_or_suspend(bs), .o_cmd_ready(rdy),
    .o_cmd_done(dn), .o_cmd_refused(rf), .o_rd_data(rd), .o_rd_valid(rv),
    .o_dummy_clocks(hdc));
  frs_asserts #(.RST_CYCLES(20)) i_frs_asserts (.i_sys_clk(clk),
    .i_sys_rst(rst), .i_cs_n(spi.cs_n), .i_sclk(spi.sclk),
    .i_miso_oe(spi.miso_oe), .i_quad_command_mode(qm),
    .i_dummy_cycle_select(sel), .i_dummy_clocks(dc),
    .i_wrap_length_select(wsel), .i_wrap_bytes(wby),
    .i_soft_reset(sr), .i_reset_busy(bz));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (rv)
      q.push_back(rd);
    if (sr)
      srs++;
  end

  // =====================================================================
  // shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task send(input logic [7:0] o, input logic [23:0] ad_v,
            input logic [7:0] pv, input logic [7:0] n);
    do begin
      @(negedge clk);
    end while (rdy !== 1'b1);
    q.delete();
    @(posedge clk);
    v <= 1;
    op <= o;
    ad <= ad_v;
    pa <= pv;
    nb <= n;
    @(posedge clk);
    v <= 0;
    do begin
      @(negedge clk);
    end while (dn !== 1'b1);
    rfd = rf;
    // last byte is queued on the edge after done
    @(negedge clk);
  endtask
  task prm(input logic s, input logic [1:0] w);
    chk(sel, s);
    chk(dc, s ? 6 : 4);
    chk(wsel, w);
    chk(wby, 8 << w);
  endtask
  task load(input logic [1:0] w);
    @(posedge clk);
    wb <= w;
    wl <= 1;
    @(posedge clk);
    wl <= 0;
  endtask
  function automatic logic [7:0] rom(input logic [10:0] x);
    if (x < 16)
      return LO[x*8 +: 8];
    if (x >= 11'h080 && x <= 11'h090)
      return HI[(x-11'h080)*8 +: 8];
    return 8'hff;
  endfunction
  task rd_chk(input logic [23:0] ra, input logic [7:0] n);
    send(8'h5a, ra, 8'h00, n);
    chk(q.size(), n);
    foreach (q[i]) chk(q[i], rom(11'(ra + i)));
  endtask

  // =====================================================================
  // tests
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    cyc(2);
    prm(0, 0);
    chk(spi.cs_n, 1);
    chk(spi.sclk, 0);
    send(8'hc0, 24'h0, 8'h13, 8'h0);
    cyc(8);
    prm(0, 0);
    $display("test spi mode parameters done");
    load(2'h2);
    qm <= 1;
    cyc(4);
    prm(0, 2);
    for (int k = 0; k < 5; k++) begin
      p = {3'h0, 1'($random(seed)), 2'h0, 2'(k)};
      if (k == 4)
        p = 8'h13;
      send(8'hc0, 24'($random(seed)), p, 8'h0);
      cyc(8);
      prm(p[4], p[1:0]);
      chk(hdc, p[4] ? 6 : 4);
    end
    $display("test quad parameters done");
    send(8'h66, 24'h0, 8'h0, 8'h0);
    chk(rfd, 0);
    rd_chk(24'h0, 8'h1);
    send(8'h99, 24'h0, 8'h0, 8'h0);
    cyc(40);
    chk(srs, 0);
    prm(1, 3);
    send(8'h66, 24'h0, 8'h0, 8'h0);
    send(8'h99, 24'h0, 8'h0, 8'h0);
    load(2'h1);
    cyc(40);
    chk(srs, 1);
    prm(0, 0);
    @(posedge clk) qm <= 0;
    load(2'h3);
    cyc(4);
    prm(0, 3);
    send(8'h66, 24'h0, 8'h0, 8'h0);
    send(8'h99, 24'h0, 8'h0, 8'h0);
    cyc(40);
    chk(srs, 2);
    prm(0, 0);
    $display("test software reset done");
    @(posedge clk) bs <= 1;
    send(8'h66, 24'h0, 8'h0, 8'h0);
    chk(rfd, 1);
    send(8'h99, 24'h0, 8'h0, 8'h0);
    chk(rfd, 1);
    @(posedge clk) bs <= 0;
    chk(srs, 2);
    $display("test refused reset done");
    rd_chk(24'hab0000, 8'd16);
    rd_chk(24'h000080, 8'd17);
    rd_chk(24'hfff7fc, 8'd6);
    for (int k = 0; k < 4; k++) begin
      a = 24'($random(seed));
      a[10:7] = 4'h0;
      rd_chk(a, {4'h0, a[14:11]} + 8'h1);
    end
    $display("test discovery reads done");
    give_verdict;
  end

  initial begin
    #2000000;
    error_cnt++;
    give_verdict;
  end
endmodule
